// ### core/ctn_core.sv
// cycle timers, nm vector accumulation and slot status selection registers
// Notes on behaviour
// R1: acceptance mask held and applied to sync filtering
// R2: six vector registers; bytes beyond length stay zero
// R3: received nm vectors ORed within a cycle
// R4: visible vector updated at cycle end only
// R5: payload byte 2n upper, 2n+1 lower
// R6: software keeps vector length at most twelve
// R7: timer one absolute; timer two mode bit
// R8: repeat bit: once-then-idle or repeating
// R9: stop trigger writes one to stop
// R10: start trigger writes one to start
// R11: running state bit readable
// R12: timers stop outside normal active/passive
// R13: timer one cycle filter value and mask
// R14: timer one macrotick offset sets expiry point
// R15: timer one config changes apply immediately
// R16: timer two config: absolute fields or count
// R17: absolute timer two uses new values immediately
// R18: relative timer two reloads only after expiry
// R19: write mode bit: all fields or selector
// R20: two-bit selector picks internal register
// R21: slot id zero captures symbol window/nit
// R22: even/odd status registers, channel b upper
// R23: status stored after selected slot ends
// R24: expiry on match or count; flag raised
// R25: one-shot timer returns idle after expiry
`timescale 1ns/1ps
`default_nettype none
module ctn_core #(
  parameter int MT_W = 14,
  parameter int CYC_W = 6
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // protocol engine events
  input wire logic poc_normal,
  input wire logic [CYC_W-1:0] cycle_count,
  input wire logic [MT_W-1:0] mt_count,
  input wire logic mt_tick,
  input wire logic cycle_end,
  input wire logic nmv_valid,
  input wire logic [95:0] nmv_payload,
  input wire logic [15:0] rx_frame_id,
  input wire logic [15:0] sync_filter_value,
  input wire logic slot_end,
  input wire logic [ctn_pkg::SLOT_ID_W-1:0] slot_id,
  input wire logic nit_end,
  input wire logic [7:0] slot_status_a,
  input wire logic [7:0] slot_status_b,
  // results
  output logic sync_id_accept,
  output logic abs_timer_expired,
  output logic second_timer_expired
);
  // counters wider than the config fields cannot be matched
  if (MT_W < 1 || MT_W > 16 || CYC_W < 1 || CYC_W > 6) begin : g_bad_width
    $error("ctn_core: unsupported counter widths");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] accept_filter_mask;
    logic sync_id_accept;
    logic [95:0] nmv_acc;
    logic [95:0] nmv_vis;
    logic [3:0] nm_vector_len_field;
    logic second_timer_rel_mode;
    logic second_timer_repeat;
    logic second_timer_running;
    logic abs_timer_repeat;
    logic abs_timer_running;
    logic [15:0] t1_cycle;
    logic [15:0] t1_offset;
    logic [15:0] t2_cfg0;
    logic [15:0] t2_cfg1;
    logic [31:0] t2_left;
    logic t2_armed;
    logic abs_timer_expired;
    logic second_timer_expired;
    logic t1_flag;
    logic t2_flag;
    logic [1:0] sel;
    logic [3:0][10:0] monitored_slot_id;
    logic [7:0][15:0] slot_stat;
  } ctn_state_s;

  ctn_state_s st_ff;
  ctn_state_s nxt_st;

  // absolute match: masked cycle bits equal and macrotick at offset
  function automatic logic abs_match(input logic [15:0] cyc,
                                     input logic [15:0] off,
                                     input logic [CYC_W-1:0] cc,
                                     input logic [MT_W-1:0] mt);
    logic [CYC_W-1:0] v;
    logic [CYC_W-1:0] m;
    v = cyc[ctn_pkg::CYC_VAL_LSB +: CYC_W];
    m = cyc[ctn_pkg::CYC_MSK_LSB +: CYC_W];
    abs_match = ((cc & m) == (v & m)) && (mt == off[MT_W-1:0]);
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic [15:0] wd;
  logic [15:0] tctl;
  logic t1_hit;
  logic t2_hit;
  logic [95:0] len_mask;
  logic [2:0] stat_idx;

  always_comb begin
    nxt_st = st_ff;
    acc = psel && penable && !st_ff.pready;
    wr = acc && pwrite;
    rd = acc && !pwrite;
    wd = pwdata[15:0];
    t1_hit = 1'b0;
    t2_hit = 1'b0;
    stat_idx = 3'd0;
    nxt_st.pready = acc;
    nxt_st.pslverr = 1'b0;
    nxt_st.abs_timer_expired = 1'b0;
    nxt_st.second_timer_expired = 1'b0;
    // masked id compare for sync frame acceptance [R1]
    nxt_st.sync_id_accept = ((rx_frame_id & ~st_ff.accept_filter_mask) ==
      (sync_filter_value & ~st_ff.accept_filter_mask));
    // bytes beyond the length never enter the accumulator [R2]
    for (int i = 0; i < ctn_pkg::NMV_BYTES; i++) begin
      len_mask[95-8*i -: 8] = (i < st_ff.nm_vector_len_field) ? 8'hff : 8'h00;
    end
    // payload byte 0 sits at [95:88], the upper byte of part 0 [R5]
    if (nmv_valid) begin
      nxt_st.nmv_acc = st_ff.nmv_acc | (nmv_payload & len_mask); // [R3]
    end
    if (cycle_end) begin
      // last vector of the cycle is folded in before the copy [R4]
      nxt_st.nmv_vis = (st_ff.nmv_acc |
        (nmv_valid ? (nmv_payload & len_mask) : 96'h0)) & len_mask;
      nxt_st.nmv_acc = 96'h0;
    end
    // timer one: always absolute, new config used at once [R7] [R13] [R14]
    if (st_ff.abs_timer_running && mt_tick &&
        abs_match(st_ff.t1_cycle, st_ff.t1_offset, cycle_count, mt_count)) begin // [R15]
      t1_hit = 1'b1;
    end
    // timer two: absolute match or relative countdown [R16] [R17]
    if (st_ff.second_timer_running && mt_tick) begin
      if (!st_ff.second_timer_rel_mode) begin
        t2_hit = abs_match(st_ff.t2_cfg0, st_ff.t2_cfg1, cycle_count, mt_count);
      end else if (st_ff.t2_left <= 32'd1) begin
        t2_hit = 1'b1; // [R24]
        // reload from config only after the running period ends [R18]
        nxt_st.t2_left = {st_ff.t2_cfg0, st_ff.t2_cfg1};
      end else begin
        nxt_st.t2_left = st_ff.t2_left - 32'd1;
      end
    end
    if (t1_hit) begin
      nxt_st.abs_timer_expired = 1'b1;
      nxt_st.t1_flag = 1'b1; // [R24]
      nxt_st.abs_timer_running = st_ff.abs_timer_repeat; // [R8] [R25]
    end
    if (t2_hit) begin
      nxt_st.second_timer_expired = 1'b1;
      nxt_st.t2_flag = 1'b1; // [R24]
      nxt_st.second_timer_running = st_ff.second_timer_repeat; // [R8] [R25]
    end
    // status capture after the chosen slot; id zero means nit/symbol [R23]
    for (int n = 0; n < 4; n++) begin
      if ((slot_end && st_ff.monitored_slot_id[n] == slot_id &&
           slot_id != '0) ||
          (nit_end && st_ff.monitored_slot_id[n] == '0)) begin // [R21]
        stat_idx = 3'(2*n + (cycle_count[0] ? 1 : 0));
        nxt_st.slot_stat[stat_idx] = {slot_status_b, slot_status_a}; // [R22]
      end
    end
    // register writes
    if (wr) begin
      unique case (paddr)
        ctn_pkg::ADDR_ACCEPT_MASK: nxt_st.accept_filter_mask = wd;
        // software keeps this at 12 or less; larger values clamp [R6]
        ctn_pkg::ADDR_NMV_LEN: nxt_st.nm_vector_len_field =
          (wd > 16'd12) ? 4'd12 : wd[3:0];
        ctn_pkg::ADDR_TIMER_CTRL: begin
          nxt_st.second_timer_rel_mode = wd[ctn_pkg::T2_REL_BIT];
          nxt_st.second_timer_repeat = wd[ctn_pkg::SECOND_TIMER_REPEAT_BIT];
          nxt_st.abs_timer_repeat = wd[ctn_pkg::ABS_TIMER_REPEAT_BIT];
          if (wd[ctn_pkg::T1_START_BIT]) begin
            nxt_st.abs_timer_running = 1'b1; // [R10]
          end
          if (wd[ctn_pkg::T2_START_BIT]) begin
            nxt_st.second_timer_running = 1'b1; // [R10]
            nxt_st.t2_left = {st_ff.t2_cfg0, st_ff.t2_cfg1};
          end
          // stop wins over start in the same write
          if (wd[ctn_pkg::T1_STOP_BIT]) begin
            nxt_st.abs_timer_running = 1'b0; // [R9]
          end
          if (wd[ctn_pkg::T2_STOP_BIT]) begin
            nxt_st.second_timer_running = 1'b0; // [R9]
          end
        end
        ctn_pkg::ADDR_T1_CYCLE: nxt_st.t1_cycle = wd;
        ctn_pkg::ADDR_T1_OFFSET: nxt_st.t1_offset = wd;
        ctn_pkg::ADDR_T2_CFG0: nxt_st.t2_cfg0 = wd;
        ctn_pkg::ADDR_T2_CFG1: nxt_st.t2_cfg1 = wd;
        ctn_pkg::ADDR_SLOT_SEL: begin
          nxt_st.sel = wd[ctn_pkg::SEL_LSB +: 2]; // [R20]
          if (!wd[ctn_pkg::SEL_WMODE_BIT]) begin // [R19]
            nxt_st.monitored_slot_id[wd[ctn_pkg::SEL_LSB +: 2]] =
              wd[ctn_pkg::SLOT_ID_W-1:0];
          end
        end
        // write one to clear; an expiry in the same cycle wins
        ctn_pkg::ADDR_TIMER_FLAGS: begin
          if (wd[0] && !t1_hit) begin
            nxt_st.t1_flag = 1'b0;
          end
          if (wd[1] && !t2_hit) begin
            nxt_st.t2_flag = 1'b0;
          end
        end
        default: nxt_st.pslverr = !(paddr >= ctn_pkg::ADDR_NMV0 &&
          paddr <= ctn_pkg::ADDR_NMV5 && paddr[1:0] == 2'b00) &&
          !(paddr >= ctn_pkg::ADDR_SLOT_STAT0 &&
          paddr <= ctn_pkg::ADDR_SLOT_STAT7 && paddr[1:0] == 2'b00);
      endcase
    end
    // leaving normal active/passive kills both timers [R12]
    if (!poc_normal) begin
      nxt_st.abs_timer_running = 1'b0;
      nxt_st.second_timer_running = 1'b0;
    end
    // register reads
    tctl = 16'h0000;
    tctl[ctn_pkg::T2_REL_BIT] = st_ff.second_timer_rel_mode;
    tctl[ctn_pkg::SECOND_TIMER_REPEAT_BIT] = st_ff.second_timer_repeat;
    tctl[ctn_pkg::T2_RUN_BIT] = st_ff.second_timer_running; // [R11]
    tctl[ctn_pkg::ABS_TIMER_REPEAT_BIT] = st_ff.abs_timer_repeat;
    tctl[ctn_pkg::T1_RUN_BIT] = st_ff.abs_timer_running; // [R11]
    nxt_st.prdata = 32'h0;
    if (rd) begin
      if (paddr >= ctn_pkg::ADDR_NMV0 && paddr <= ctn_pkg::ADDR_NMV5 &&
          paddr[1:0] == 2'b00) begin
        nxt_st.prdata[15:0] = st_ff.nmv_vis[95-16*((paddr-8'h04)>>2) -: 16];
      end else if (paddr >= ctn_pkg::ADDR_SLOT_STAT0 &&
                   paddr <= ctn_pkg::ADDR_SLOT_STAT7 &&
                   paddr[1:0] == 2'b00) begin
        nxt_st.prdata[15:0] = st_ff.slot_stat[3'((paddr-8'h40)>>2)];
      end else begin
        unique case (paddr)
          ctn_pkg::ADDR_ACCEPT_MASK: nxt_st.prdata[15:0] = st_ff.accept_filter_mask;
          ctn_pkg::ADDR_NMV_LEN: nxt_st.prdata[3:0] = st_ff.nm_vector_len_field;
          ctn_pkg::ADDR_TIMER_CTRL: nxt_st.prdata[15:0] = tctl;
          ctn_pkg::ADDR_T1_CYCLE: nxt_st.prdata[15:0] = st_ff.t1_cycle;
          ctn_pkg::ADDR_T1_OFFSET: nxt_st.prdata[15:0] = st_ff.t1_offset;
          ctn_pkg::ADDR_T2_CFG0: nxt_st.prdata[15:0] = st_ff.t2_cfg0;
          ctn_pkg::ADDR_T2_CFG1: nxt_st.prdata[15:0] = st_ff.t2_cfg1;
          ctn_pkg::ADDR_SLOT_SEL: nxt_st.prdata[15:0] =
            {2'b00, st_ff.sel, 1'b0, st_ff.monitored_slot_id[st_ff.sel]};
          ctn_pkg::ADDR_TIMER_FLAGS: nxt_st.prdata[1:0] =
            {st_ff.t2_flag, st_ff.t1_flag};
          default: nxt_st.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign sync_id_accept = st_ff.sync_id_accept;
  assign abs_timer_expired = st_ff.abs_timer_expired;
  assign second_timer_expired = st_ff.second_timer_expired;

  property p_stop_outside_normal;
    @(posedge clock) disable iff (!arst_n)
      !poc_normal |=> !st_ff.abs_timer_running && !st_ff.second_timer_running;
  endproperty
  a_stop_outside_normal: assert property (p_stop_outside_normal) // [R12]
    else $error("timer running outside normal state");

  property p_oneshot_idle;
    @(posedge clock) disable iff (!arst_n)
      abs_timer_expired && !st_ff.abs_timer_repeat |-> !st_ff.abs_timer_running;
  endproperty
  a_oneshot_idle: assert property (p_oneshot_idle) // [R25]
    else $error("one-shot timer one still running after expiry");

  property p_vis_cycle_end;
    @(posedge clock) disable iff (!arst_n)
      !cycle_end |=> $stable(st_ff.nmv_vis);
  endproperty
  a_vis_cycle_end: assert property (p_vis_cycle_end) // [R4]
    else $error("visible vector changed mid-cycle");

  property p_len_zero;
    @(posedge clock) disable iff (!arst_n)
      (st_ff.nmv_vis & ~len_mask) == 96'h0;
  endproperty
  a_len_zero: assert property (p_len_zero) // [R2]
    else $error("unused vector bytes not zero");

  property p_start;
    @(posedge clock) disable iff (!arst_n)
      wr && paddr == ctn_pkg::ADDR_TIMER_CTRL && wd[ctn_pkg::T1_START_BIT] &&
      !wd[ctn_pkg::T1_STOP_BIT] && poc_normal |=> st_ff.abs_timer_running;
  endproperty
  a_start: assert property (p_start) // [R10]
    else $error("start trigger did not start timer one");

  property p_stop;
    @(posedge clock) disable iff (!arst_n)
      wr && paddr == ctn_pkg::ADDR_TIMER_CTRL && wd[ctn_pkg::T2_STOP_BIT]
      |=> !st_ff.second_timer_running;
  endproperty
  a_stop: assert property (p_stop) // [R9]
    else $error("stop trigger did not stop timer two");

  property p_expire_flag;
    @(posedge clock) disable iff (!arst_n)
      second_timer_expired |-> st_ff.t2_flag;
  endproperty
  a_expire_flag: assert property (p_expire_flag) // [R24]
    else $error("expiry without flag");

  property p_t1_flag;
    @(posedge clock) disable iff (!arst_n)
      abs_timer_expired |-> st_ff.t1_flag;
  endproperty
  a_t1_flag: assert property (p_t1_flag) // [R24]
    else $error("timer one expiry without flag");

  property p_t2_oneshot;
    @(posedge clock) disable iff (!arst_n)
      second_timer_expired && !st_ff.second_timer_repeat |-> !st_ff.second_timer_running;
  endproperty
  a_t2_oneshot: assert property (p_t2_oneshot) // [R25]
    else $error("one-shot timer two still running after expiry");

  property p_sel1_capture;
    @(posedge clock) disable iff (!arst_n)
      slot_end && slot_id != '0 && st_ff.monitored_slot_id[1] == slot_id
      |=> st_ff.slot_stat[{2'b01, $past(cycle_count[0])}] ==
        $past({slot_status_b, slot_status_a});
  endproperty
  a_sel1_capture: assert property (p_sel1_capture) // [R22]
    else $error("selected slot status not stored");

  property p_apb_ready;
    @(posedge clock) disable iff (!arst_n)
      psel && penable && !pready |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb access not answered in one cycle");
endmodule
`default_nettype wire

// ### shared/ctn_pkg.sv
// package: register map, field positions and reset values for the cycle timer / nm block
package ctn_pkg;
  // register byte addresses (apb, one 32-bit word each)
  localparam logic [7:0] ADDR_ACCEPT_MASK = 8'h00;
  localparam logic [7:0] ADDR_NMV0 = 8'h04;
  localparam logic [7:0] ADDR_NMV5 = 8'h18;
  localparam logic [7:0] ADDR_NMV_LEN = 8'h1c;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h20;
  localparam logic [7:0] ADDR_T1_CYCLE = 8'h24;
  localparam logic [7:0] ADDR_T1_OFFSET = 8'h28;
  localparam logic [7:0] ADDR_T2_CFG0 = 8'h2c;
  localparam logic [7:0] ADDR_T2_CFG1 = 8'h30;
  localparam logic [7:0] ADDR_SLOT_SEL = 8'h34;
  localparam logic [7:0] ADDR_SLOT_READ = 8'h38;
  localparam logic [7:0] ADDR_TIMER_FLAGS = 8'h3c;
  localparam logic [7:0] ADDR_SLOT_STAT0 = 8'h40;
  localparam logic [7:0] ADDR_SLOT_STAT7 = 8'h5c;
  // timer control bits
  localparam int T2_REL_BIT = 15;
  localparam int SECOND_TIMER_REPEAT_BIT = 14;
  localparam int T2_STOP_BIT = 10;
  localparam int T2_START_BIT = 9;
  localparam int T2_RUN_BIT = 8;
  localparam int ABS_TIMER_REPEAT_BIT = 6;
  localparam int T1_STOP_BIT = 2;
  localparam int T1_START_BIT = 1;
  localparam int T1_RUN_BIT = 0;
  // cycle set: value in [5:0], mask in [13:8]
  localparam int CYC_VAL_LSB = 0;
  localparam int CYC_MSK_LSB = 8;
  // slot select: write mode bit, selector, slot id
  localparam int SEL_WMODE_BIT = 15;
  localparam int SEL_LSB = 12;
  localparam int SLOT_ID_W = 11;
  // nm vector
  localparam int NMV_BYTES = 12;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
endpackage

// ### dv/ctn_pe_model.sv
// protocol engine stand-in: cycle, macrotick, nm vector and slot events
`timescale 1ns/1ps
`default_nettype none
module ctn_pe_model (
  // clock
  input wire logic clock,
  // events towards the block
  output logic poc_normal,
  output logic [5:0] cycle_count,
  output logic [13:0] mt_count,
  output logic mt_tick,
  output logic cycle_end,
  output logic nmv_valid,
  output logic [95:0] nmv_payload,
  output logic slot_end,
  output logic [10:0] slot_id,
  output logic nit_end,
  output logic [7:0] slot_status_a,
  output logic [7:0] slot_status_b
);
  initial begin
    poc_normal = 1'b1;
    cycle_count = '0;
    mt_count = '0;
    mt_tick = 1'b0;
    cycle_end = 1'b0;
    nmv_valid = 1'b0;
    nmv_payload = '0;
    slot_end = 1'b0;
    slot_id = '0;
    nit_end = 1'b0;
    slot_status_a = '0;
    slot_status_b = '0;
  end
  // one macrotick every two clocks; the count is valid with the tick
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      mt_tick <= 1'b1;
      @(posedge clock);
      mt_tick <= 1'b0;
      mt_count <= mt_count + 14'h1;
    end
  endtask
  task automatic end_cycle();
    @(posedge clock);
    cycle_end <= 1'b1;
    @(posedge clock);
    cycle_end <= 1'b0;
    cycle_count <= cycle_count + 6'h1;
    mt_count <= '0;
  endtask
  // a cycle of eight macroticks, offsets 0..7
  task automatic cycles(input int n);
    repeat (n) begin
      ticks(8);
      end_cycle();
    end
  endtask
  // released data lines show the inverse, never the last value
  task automatic send_nmv(input logic [95:0] v);
    @(posedge clock);
    nmv_valid <= 1'b1;
    nmv_payload <= v;
    @(posedge clock);
    nmv_valid <= 1'b0;
    nmv_payload <= ~v;
  endtask
  task automatic slot_ev(input logic [10:0] id, input logic [7:0] a,
                         input logic [7:0] b, input logic nit);
    @(posedge clock);
    slot_id <= id;
    slot_status_a <= a;
    slot_status_b <= b;
    slot_end <= ~nit;
    nit_end <= nit;
    @(posedge clock);
    slot_end <= 1'b0;
    nit_end <= 1'b0;
    slot_id <= ~id;
    slot_status_a <= ~a;
    slot_status_b <= ~b;
  endtask
  task automatic set_poc(input logic v);
    @(posedge clock);
    poc_normal <= v;
  endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the cycle timer / nm vector block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_frame_id, sync_filter_value;
  logic sync_id_accept, t1x, t2x, poc_normal, mt_tick, cycle_end;
  logic nmv_valid, slot_end, nit_end;
  logic [5:0] cycle_count;
  logic [13:0] mt_count;
  logic [95:0] nmv_payload;
  logic [10:0] slot_id;
  logic [7:0] slot_status_a, slot_status_b;
  int n_fail, n_checks, n_t1, n_t2, p, b;
  ctn_core dut_u (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .poc_normal(poc_normal), .cycle_count(cycle_count),
    .mt_count(mt_count), .mt_tick(mt_tick), .cycle_end(cycle_end),
    .nmv_valid(nmv_valid), .nmv_payload(nmv_payload),
    .rx_frame_id(rx_frame_id), .sync_filter_value(sync_filter_value),
    .slot_end(slot_end), .slot_id(slot_id), .nit_end(nit_end),
    .slot_status_a(slot_status_a), .slot_status_b(slot_status_b),
    .sync_id_accept(sync_id_accept), .abs_timer_expired(t1x),
    .second_timer_expired(t2x));
  ctn_pe_model pe_u (.clock(clock), .poc_normal(poc_normal),
    .cycle_count(cycle_count), .mt_count(mt_count), .mt_tick(mt_tick),
    .cycle_end(cycle_end), .nmv_valid(nmv_valid),
    .nmv_payload(nmv_payload), .slot_end(slot_end), .slot_id(slot_id),
    .nit_end(nit_end), .slot_status_a(slot_status_a),
    .slot_status_b(slot_status_b));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // expiry pulses last one cycle, so they are counted on every edge
  always @(posedge clock) begin
    if (t1x === 1'b1) n_t1++;
    if (t2x === 1'b1) n_t2++;
  end
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held from setup until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  function automatic logic [7:0] ss(input int n);
    return ctn_pkg::ADDR_SLOT_STAT0 + 8'(4 * n);
  endfunction
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_frame_id = 16'h0123;
    sync_filter_value = 16'h0120;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    wr(ctn_pkg::ADDR_ACCEPT_MASK, 32'h000f);
    repeat (2) @(posedge clock);
    chk("accept", 32'h1, {31'h0, sync_id_accept});
    wr(ctn_pkg::ADDR_ACCEPT_MASK, 32'h0000);
    repeat (2) @(posedge clock);
    chk("reject", 32'h0, {31'h0, sync_id_accept});
    sync_filter_value <= 16'h0133;
    wr(ctn_pkg::ADDR_ACCEPT_MASK, 32'h0010);
    repeat (2) @(posedge clock);
    chk("masked bit", 32'h1, {31'h0, sync_id_accept});
    rx_frame_id <= 16'h8123;
    repeat (2) @(posedge clock);
    chk("id bit", 32'h0, {31'h0, sync_id_accept});
    wr(ctn_pkg::ADDR_NMV_LEN, 32'h3);
    pe_u.send_nmv({8'h01, 8'h10, 8'h20, {9{8'hff}}});
    pe_u.send_nmv({8'h80, 8'h01, 8'h04, {9{8'h5a}}});
    rc(ctn_pkg::ADDR_NMV0, 32'hffff, 32'h0, "nmv early");
    pe_u.end_cycle();
    rc(ctn_pkg::ADDR_NMV0, 32'hffff, 32'h8111, "nmv0");
    rc(ctn_pkg::ADDR_NMV0 + 8'h4, 32'hffff, 32'h2400, "nmv1");
    rc(ctn_pkg::ADDR_NMV5, 32'hffff, 32'h0, "nmv5");
    pe_u.end_cycle();
    rc(ctn_pkg::ADDR_NMV0, 32'hffff, 32'h0, "nmv last");
    wr(ctn_pkg::ADDR_NMV0, 32'hffff);
    // read-only parts answer without error and keep their value
    chk("ro err", 32'h0, {31'h0, err});
    rc(ctn_pkg::ADDR_NMV0, 32'hffff, 32'h0, "ro kept");
    apb(1'b0, ctn_pkg::ADDR_SLOT_READ, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    // absolute timer: odd cycles, offset 5, one shot
    wr(ctn_pkg::ADDR_T1_CYCLE, 32'h0101);
    wr(ctn_pkg::ADDR_T1_OFFSET, 32'h5);
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h1 << ctn_pkg::T1_START_BIT);
    rc(ctn_pkg::ADDR_TIMER_CTRL, 32'h101, 32'h1, "t1 run");
    b = n_t1;
    pe_u.cycles(4);
    chk("t1 once", 32'h1, n_t1 - b);
    rc(ctn_pkg::ADDR_TIMER_CTRL, 32'h101, 32'h0, "t1 idle");
    rc(ctn_pkg::ADDR_TIMER_FLAGS, 32'h3, 32'h1, "t1 flag");
    wr(ctn_pkg::ADDR_TIMER_FLAGS, 32'h1);
    rc(ctn_pkg::ADDR_TIMER_FLAGS, 32'h3, 32'h0, "flag clr");
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h42);
    b = n_t1;
    pe_u.cycles(4);
    chk("t1 repeat", 32'h2, n_t1 - b);
    wr(ctn_pkg::ADDR_T1_CYCLE, 32'h0000);
    b = n_t1;
    pe_u.cycles(2);
    chk("t1 new filter", 32'h2, n_t1 - b);
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h1 << ctn_pkg::T1_STOP_BIT);
    rc(ctn_pkg::ADDR_TIMER_CTRL, 32'h101, 32'h0, "t1 stop");
    b = n_t1;
    pe_u.cycles(1);
    chk("t1 stopped", 32'h0, n_t1 - b);
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h42);
    pe_u.set_poc(1'b0);
    rc(ctn_pkg::ADDR_TIMER_CTRL, 32'h101, 32'h0, "poc off");
    pe_u.set_poc(1'b1);
    // relative second timer: four macroticks, changed to two mid-run
    wr(ctn_pkg::ADDR_T2_CFG0, 32'h0);
    wr(ctn_pkg::ADDR_T2_CFG1, 32'h4);
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'hc200);
    b = n_t2;
    pe_u.ticks(1);
    wr(ctn_pkg::ADDR_T2_CFG1, 32'h2);
    pe_u.ticks(3);
    // the pulse of the last tick stands one edge later
    repeat (2) @(posedge clock);
    chk("t2 old count", 32'h1, n_t2 - b);
    pe_u.ticks(4);
    repeat (2) @(posedge clock);
    chk("t2 new count", 32'h3, n_t2 - b);
    // a cycle end brings the macrotick count back to zero
    pe_u.end_cycle();
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h1 << ctn_pkg::T2_STOP_BIT);
    wr(ctn_pkg::ADDR_T2_CFG1, 32'h3);
    wr(ctn_pkg::ADDR_TIMER_CTRL, 32'h1 << ctn_pkg::T2_START_BIT);
    b = n_t2;
    wr(ctn_pkg::ADDR_T2_CFG1, 32'h6);
    pe_u.cycles(1);
    chk("t2 abs", 32'h1, n_t2 - b);
    rc(ctn_pkg::ADDR_TIMER_CTRL, 32'h101, 32'h0, "t2 idle");
    // slot selection: internal register 1 watches slot 7
    wr(ctn_pkg::ADDR_SLOT_SEL, 32'h1007);
    p = cycle_count[0];
    pe_u.slot_ev(11'h7, 8'h3c, 8'ha5, 1'b0);
    rc(ss(2 + p), 32'hffff, 32'ha53c, "slot sel1");
    wr(ctn_pkg::ADDR_SLOT_SEL, 32'h9009);
    pe_u.slot_ev(11'h7, 8'h11, 8'h22, 1'b0);
    pe_u.slot_ev(11'h9, 8'h55, 8'h66, 1'b0);
    rc(ss(2 + p), 32'hffff, 32'h2211, "sel only");
    pe_u.end_cycle();
    pe_u.slot_ev(11'h7, 8'h44, 8'h33, 1'b0);
    rc(ss(3 - p), 32'hffff, 32'h3344, "parity");
    wr(ctn_pkg::ADDR_SLOT_SEL, 32'h0000);
    pe_u.slot_ev(11'h0, 8'h77, 8'h88, 1'b1);
    rc(ss(1 - p), 32'hffff, 32'h8877, "nit");
    end_sim();
  end
endmodule
`default_nettype wire
